/* shared/elcr_pkg.sv */
package elcr_pkg;
  // ----------------------------------------------------------------
  // register indices (byte address = 4 * index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_MONITOR_SEL = 8'h0B;
  localparam logic [7:0] IDX_DLB_EN = 8'h0C;
  localparam logic [7:0] IDX_LOS_STD = 8'h0D;
  localparam logic [7:0] IDX_AUTO_ONES = 8'h0E;
  localparam logic [7:0] IDX_GLOBAL = 8'h0F;
  localparam logic [7:0] IDX_WAVE_ADDR = 8'h17;
  localparam logic [7:0] IDX_WAVE_DATA = 8'h40;
  localparam logic [7:0] IDX_STATUS = 8'h41;
  localparam int ADDR_W = 10;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int MON_CODE_HI = 3;
  localparam int GC_AUTOINC = 7;
  localparam int GC_RX_AIS = 6;
  localparam int GC_RSVD = 5;
  localparam int GC_CODE = 4;
  localparam int GC_FIFO = 3;
  localparam int GC_CORNER = 2;
  localparam int GC_POS_HI = 1;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] MON_MASK = 8'h0F;
  localparam logic [7:0] GC_MASK = 8'hDF;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // jitter attenuator placement
  typedef enum logic [1:0] {
    ELCR_JA_OFF = 2'b00,
    ELCR_JA_TX = 2'b01,
    ELCR_JA_RX = 2'b11
  } elcr_ja_type;

  // per-line controls for the eight channels
  typedef struct packed {
    logic [7:0] loopback;
    logic [7:0] etsi_mode;
    logic [7:0] send_all_ones;
    logic [7:0] rx_ais_insert;
    logic [7:0] ami_code;
    logic [7:0] ja_tx;
    logic [7:0] ja_rx;
    logic [7:0] ja_fifo_long;
    logic [7:0] ja_corner_hi;
  } elcr_line_ctrl_type;

  // monitor routing
  typedef struct packed {
    logic active;
    logic [2:0] channel;
    logic transmit;
  } elcr_monitor_type;
endpackage : elcr_pkg

/* src/elcr_regs.sv */
// Decided for this implementation: the AXI4-Lite slave port.
module elcr_regs #(
  parameter int CHANNELS = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [elcr_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [elcr_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // line status
  input wire logic [7:0] los_detect,
  // line controls
  output elcr_pkg::elcr_line_ctrl_type line_ctrl,
  output elcr_pkg::elcr_monitor_type monitor,
  output logic [7:0] wave_addr
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    // bus side: captured requests and pending answers
    logic aw_held;
    logic [elcr_pkg::ADDR_W-1:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    // ready flags, kept in flops so the bus sees registered outputs
    logic aw_rdy;
    logic w_rdy;
    logic ar_rdy;
    // software-visible control registers
    logic [7:0] mon_sel;
    logic [7:0] dlb;
    logic [7:0] los_std;
    logic [7:0] auto_ones;
    logic [7:0] gctl;
    // waveform table access window
    logic [7:0] wave_addr;
    logic [7:0] wave_data;
    // decoded controls driven to the line side
    elcr_pkg::elcr_line_ctrl_type line;
    elcr_pkg::elcr_monitor_type mon;
  } elcr_state_type;

  elcr_state_type s_q;
  elcr_state_type s_d;

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------

  // byte address to register index; low two bits must be zero
  function automatic logic [7:0] reg_index(input logic [elcr_pkg::ADDR_W-1:0] a);
    reg_index = a[elcr_pkg::ADDR_W-1:2];
  endfunction : reg_index

  // valid register word at this address
  function automatic logic mapped(input logic [elcr_pkg::ADDR_W-1:0] a);
    logic [7:0] i;
    i = reg_index(a);
    mapped = (a[1:0] == 2'b00) && ((i >= elcr_pkg::IDX_MONITOR_SEL && i <= elcr_pkg::IDX_GLOBAL)
      || i == elcr_pkg::IDX_WAVE_ADDR || i == elcr_pkg::IDX_WAVE_DATA || i == elcr_pkg::IDX_STATUS);
  endfunction : mapped

  // one global bit fanned out to every channel
  function automatic logic [CHANNELS-1:0] spread(input logic b);
    spread = {CHANNELS{b}};
  endfunction : spread

  // monitor code: 0 idle, 1..7 rx of channel, 8 idle, 9..15 tx of channel
  function automatic elcr_pkg::elcr_monitor_type mon_decode(input logic [3:0] code);
    mon_decode.channel = code[2:0];
    mon_decode.transmit = code[elcr_pkg::MON_CODE_HI];
    mon_decode.active = (code[2:0] != 3'b000);
  endfunction : mon_decode

  // ----------------------------------------------------------------
  // working signals
  // ----------------------------------------------------------------
  // decoded bus events, valid only within the current cycle
  logic wr_go;
  logic rd_go;
  logic [7:0] wr_idx;
  logic [7:0] rd_idx;
  logic [7:0] wbyte;
  logic [1:0] ja_code;
  // read address as seen this cycle; a read is taken straight from the bus
  logic [elcr_pkg::ADDR_W-1:0] s_araddr_w;
  assign s_araddr_w = s_axi_araddr;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    wr_idx = reg_index(s_q.awaddr);
    rd_idx = reg_index(s_araddr_w);
    wbyte = s_q.wdata[7:0];
    // write once both halves held and response slot is free
    wr_go = s_q.aw_held && s_q.w_held && !s_q.bvalid;
    rd_go = s_axi_arvalid && s_q.ar_rdy;

    // catch address and data in either order
    if (s_axi_awvalid && s_q.aw_rdy) begin
      s_d.aw_held = 1'b1;
      s_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_q.w_rdy) begin
      s_d.w_held = 1'b1;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end

    // register write; only byte lane 0 carries data
    if (wr_go) begin
      s_d.aw_held = 1'b0;
      s_d.w_held = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = mapped(s_q.awaddr) ? elcr_pkg::RESP_OKAY : elcr_pkg::RESP_SLVERR;
      if (mapped(s_q.awaddr) && s_q.wstrb[0]) begin
        case (wr_idx)
          // reserved bits are masked, so a careless host cannot disturb them
          elcr_pkg::IDX_MONITOR_SEL: s_d.mon_sel = wbyte & elcr_pkg::MON_MASK;
          elcr_pkg::IDX_DLB_EN: s_d.dlb = wbyte;
          elcr_pkg::IDX_LOS_STD: s_d.los_std = wbyte;
          elcr_pkg::IDX_AUTO_ONES: s_d.auto_ones = wbyte;
          elcr_pkg::IDX_GLOBAL: s_d.gctl = wbyte & elcr_pkg::GC_MASK;
          elcr_pkg::IDX_WAVE_ADDR: s_d.wave_addr = wbyte;
          elcr_pkg::IDX_WAVE_DATA: begin
            s_d.wave_data = wbyte;
            if (s_q.gctl[elcr_pkg::GC_AUTOINC]) begin
              s_d.wave_addr = s_q.wave_addr + 8'h01;
            end
          end
          default: ;
        endcase
      end
    end

    // register read
    if (rd_go) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = mapped(s_axi_araddr) ? elcr_pkg::RESP_OKAY : elcr_pkg::RESP_SLVERR;
      s_d.rdata = 32'h0000_0000;
      if (mapped(s_axi_araddr)) begin
        case (rd_idx)
          elcr_pkg::IDX_MONITOR_SEL: s_d.rdata[7:0] = s_q.mon_sel;
          elcr_pkg::IDX_DLB_EN: s_d.rdata[7:0] = s_q.dlb;
          elcr_pkg::IDX_LOS_STD: s_d.rdata[7:0] = s_q.los_std;
          elcr_pkg::IDX_AUTO_ONES: s_d.rdata[7:0] = s_q.auto_ones;
          elcr_pkg::IDX_GLOBAL: s_d.rdata[7:0] = s_q.gctl;
          elcr_pkg::IDX_WAVE_ADDR: s_d.rdata[7:0] = s_q.wave_addr;
          elcr_pkg::IDX_WAVE_DATA: begin
            s_d.rdata[7:0] = s_q.wave_data;
            // a read also advances; a same-cycle write bump is added to, so the address moves by two
            if (s_q.gctl[elcr_pkg::GC_AUTOINC]) begin
              s_d.wave_addr = s_d.wave_addr + 8'h01;
            end
          end
          elcr_pkg::IDX_STATUS: s_d.rdata[7:0] = s_q.line.send_all_ones;
          default: ;
        endcase
      end
    end

    // per-channel masks pass straight through, one cycle behind the registers
    s_d.line.loopback = s_q.dlb;
    s_d.line.etsi_mode = s_q.los_std;
    // all-ones only while the channel reported loss of signal a cycle earlier; drops one cycle after it
    s_d.line.send_all_ones = s_q.auto_ones & los_detect;

    // global bits drive every channel alike, so no channel can disagree
    s_d.line.rx_ais_insert = spread(s_q.gctl[elcr_pkg::GC_RX_AIS]);
    s_d.line.ami_code = spread(s_q.gctl[elcr_pkg::GC_CODE]);
    s_d.line.ja_fifo_long = spread(s_q.gctl[elcr_pkg::GC_FIFO]);
    s_d.line.ja_corner_hi = spread(s_q.gctl[elcr_pkg::GC_CORNER]);

    // attenuator placement; the spare code 10 is treated as off
    ja_code = s_q.gctl[elcr_pkg::GC_POS_HI:0];
    s_d.line.ja_tx = spread(1'b0);
    s_d.line.ja_rx = spread(1'b0);
    case (ja_code)
      elcr_pkg::ELCR_JA_TX: s_d.line.ja_tx = spread(1'b1);
      elcr_pkg::ELCR_JA_RX: s_d.line.ja_rx = spread(1'b1);
      default: ; // 00 and 10 leave it out
    endcase

    // monitor routing from the low select bits only
    s_d.mon = mon_decode(s_q.mon_sel[elcr_pkg::MON_CODE_HI:0]);

    // ready flags mirror the next held or rvalid state, so each ready is a flop output
    s_d.aw_rdy = !s_d.aw_held;
    s_d.w_rdy = !s_d.w_held;
    s_d.ar_rdy = !s_d.rvalid;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0; // every control register to 00h
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // write channels; readies stay low for one cycle after reset
  assign s_axi_awready = s_q.aw_rdy;
  assign s_axi_wready = s_q.w_rdy;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;

  // read channels
  assign s_axi_arready = s_q.ar_rdy;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rresp = s_q.rresp;
  assign s_axi_rdata = s_q.rdata;

  // line side, all straight from the state flops
  assign line_ctrl = s_q.line;
  assign monitor = s_q.mon;
  assign wave_addr = s_q.wave_addr;
endmodule : elcr_regs

/* test/elcr_checker.sv */
module elcr_checker (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // watched pins
  input wire logic [7:0] los_detect,
  input wire elcr_pkg::elcr_line_ctrl_type line_ctrl,
  input wire elcr_pkg::elcr_monitor_type monitor
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // line controls clear on the first reset edge with the registers; two are allowed
  a_reset_clear: assert property (disable iff (1'b0) !aresetn [*2] |=> line_ctrl == '0 && monitor == '0)
    else $error("controls not cleared by reset");
  a_ones_need_los: assert property ((line_ctrl.send_all_ones & ~$past(los_detect)) == 8'h00)
    else $error("all ones sent without loss of signal");
  a_ais_uniform: assert property (line_ctrl.rx_ais_insert inside {8'h00, 8'hff})
    else $error("alarm insert differs between channels");
  a_code_uniform: assert property (line_ctrl.ami_code inside {8'h00, 8'hff})
    else $error("line code differs between channels");
  a_fifo_uniform: assert property (line_ctrl.ja_fifo_long inside {8'h00, 8'hff})
    else $error("fifo length differs between channels");
  a_corner_uniform: assert property (line_ctrl.ja_corner_hi inside {8'h00, 8'hff})
    else $error("corner differs between channels");
  a_ja_exclusive: assert property ((line_ctrl.ja_tx & line_ctrl.ja_rx) == 8'h00
    && line_ctrl.ja_tx inside {8'h00, 8'hff})
    else $error("attenuator placed twice or unevenly");
  a_mon_active: assert property (monitor.active == (monitor.channel != 3'b000))
    else $error("monitor active flag wrong");
  c_ones: cover property (|line_ctrl.send_all_ones);
  c_mon_tx: cover property (monitor.active && monitor.transmit);
  c_ja_rx: cover property (line_ctrl.ja_rx == 8'hff);
endmodule : elcr_checker

bind elcr_regs elcr_checker chk (.aclk(aclk), .aresetn(aresetn), .los_detect(los_detect), .line_ctrl(line_ctrl),
  .monitor(monitor));

/* test/elcr_host.sv */
module elcr_host (
  // clock
  input wire logic aclk,
  // requests
  output logic [9:0] awaddr,
  output logic [9:0] araddr,
  output logic [31:0] wdata,
  output logic awvalid,
  output logic wvalid,
  output logic arvalid,
  // answers
  input wire logic awready,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic arready,
  input wire logic rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {awvalid, wvalid, arvalid} = 3'b000;
    {awaddr, araddr, wdata} = '0;
  end
  // released payloads flip so stale values never look valid
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    fork
      begin
        @(posedge aclk iff awready);
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      begin
        @(posedge aclk iff wready);
        wvalid <= 1'b0;
        wdata <= ~{24'h0, d};
      end
    join
    @(posedge aclk iff bvalid);
  endtask : wr
  task automatic rd(input logic [9:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    @(posedge aclk iff arready);
    arvalid <= 1'b0;
    araddr <= ~a;
    @(posedge aclk iff rvalid);
  endtask : rd
endmodule : elcr_host

/* test/tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [1:0] OK = elcr_pkg::RESP_OKAY;
  localparam logic [1:0] ER = elcr_pkg::RESP_SLVERR;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid;
  logic [9:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [7:0] los_detect, wave_addr, v;
  logic [7:0] w [16];
  logic [31:0] rng = 32'd99;
  logic [33:0] exp_r [$];
  logic [1:0] exp_b [$];
  int num_errors = 0;
  int checks = 0;
  elcr_pkg::elcr_line_ctrl_type line_ctrl;
  elcr_pkg::elcr_monitor_type monitor;
  elcr_host host (.aclk(aclk), .awaddr(awaddr), .araddr(araddr), .wdata(wdata), .awvalid(awvalid), .wvalid(wvalid),
    .arvalid(arvalid), .awready(awready), .wready(wready), .bvalid(bvalid), .arready(arready), .rvalid(rvalid));
  elcr_regs dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .los_detect(los_detect), .line_ctrl(line_ctrl), .monitor(monitor), .wave_addr(wave_addr));
  function automatic logic [7:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng[7:0];
  endfunction : rnd
  task automatic chk(input string what, input logic [33:0] e, input logic [33:0] s);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, e, s);
    end
  endtask : chk
  task automatic wr_chk(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] r);
    exp_b.push_back(r);
    host.wr({idx, 2'b00}, d);
  endtask : wr_chk
  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] r);
    exp_r.push_back({r, 24'h0, d});
    host.rd({idx, 2'b00});
  endtask : rd_chk
  task automatic stop_test();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  // answers are matched in order against the notes
  always @(posedge aclk) begin
    if (bvalid) chk("bresp", exp_b.pop_front(), bresp);
    if (rvalid) chk("read", exp_r.pop_front(), {rresp, rdata});
  end
  // a hang costs far more than the hundred or so cycles needed
  initial begin
    #1_000_000;
    num_errors++;
    stop_test();
  end
  initial begin
    aresetn = 1'b0;
    los_detect = 8'h00;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 11; i < 16; i++) rd_chk(i[7:0], 8'h00, OK);
    $display("test reset values done");
    // random contents, reserved bits kept at zero by the host
    for (int i = 11; i < 16; i++) begin
      w[i] = rnd();
      if (i == 11) w[i] = w[i] & elcr_pkg::MON_MASK;
      if (i == 15) w[i] = w[i] & elcr_pkg::GC_MASK;
      wr_chk(i[7:0], w[i], OK);
      rd_chk(i[7:0], w[i], OK);
    end
    chk("loopback", w[12], line_ctrl.loopback);
    chk("etsi", w[13], line_ctrl.etsi_mode);
    los_detect <= rnd();
    repeat (3) @(posedge aclk);
    chk("all_ones", w[14] & los_detect, line_ctrl.send_all_ones);
    rd_chk(8'h41, w[14] & los_detect, OK);
    $display("test channel masks done");
    for (int p = 0; p < 4; p++) begin
      v = (rnd() & 8'hdc) | p[7:0];
      wr_chk(8'h0f, v, OK);
      rd_chk(8'h0f, v, OK);
      chk("ja_tx", {8{p == 1}}, line_ctrl.ja_tx);
      chk("ja_rx", {8{p == 3}}, line_ctrl.ja_rx);
      chk("ais", {8{v[6]}}, line_ctrl.rx_ais_insert);
      chk("ami", {8{v[4]}}, line_ctrl.ami_code);
      chk("ja_cfg", {{8{v[3]}}, {8{v[2]}}}, {line_ctrl.ja_fifo_long, line_ctrl.ja_corner_hi});
    end
    $display("test global done");
    wr_chk(8'h0f, 8'h80, OK);
    v = rnd();
    wr_chk(8'h17, v, OK);
    wr_chk(8'h40, 8'h5a, OK);
    rd_chk(8'h40, 8'h5a, OK);
    rd_chk(8'h17, v + 8'd2, OK);
    chk("wave_addr", 8'(v + 8'd2), wave_addr);
    wr_chk(8'h0b, 8'h0b, OK);
    rd_chk(8'h0b, 8'h0b, OK);
    chk("monitor", 5'b1_011_1, monitor);
    wr_chk(8'hff, 8'h55, ER);
    rd_chk(8'hff, 8'h00, ER);
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(8'h0f, 8'h00, OK);
    $display("test misc done");
    repeat (2) @(posedge aclk);
    stop_test();
  end
endmodule : tb
